// File: rtl/srpf_ctrl.sv
/*
 sleep entry and wake, reset source collection, start-up delay and power-fail setup.
 assumes the cpu core, timers, watchdog and analog detectors sit outside and use the
 strobes and levels below; all inputs are synchronous to CORE_CLK.
*/
// Function
// RULE_01 - writing 0fh to the sleep control register enters sleep
// RULE_02 - hardware clears the sleep control register once sleep is accepted
// RULE_03 - sleep halts cpu; timer_zero, timebase and watchdog keep counting
// RULE_04 - port pins keep their data and direction levels during sleep
// RULE_05 - sleep ends on hardware reset or any interrupt source
// RULE_06 - reset wake reinitialises control registers; interrupt wake keeps them
// RULE_07 - pin-change wake produces a full system reset
// RULE_08 - interrupt wake vectors if master enable set, else resumes in line
// RULE_09 - interrupt or timer wake resumes with no stabilisation wait
// RULE_10 - software follows the sleep write with at least two no-ops
// RULE_11 - external reset pin held low at least 8 oscillator periods
// RULE_12 - after reset, wait 65.5 ms plus 7 periods before executing
// RULE_13 - no reset source alters ram contents
// RULE_14 - five reset sources combine into the system reset
// RULE_15 - supply-rise reset holds device until supply is adequate
// RULE_16 - with reset pin fuse cleared, the pin is an ordinary input
// RULE_17 - power-fail register enables detector, filter, and reset or freeze action
// RULE_18 - enable switches detector on; level select picks high or low threshold
// RULE_19 - configuration area reachable only in program and verify mode
// RULE_20 - interrupt master enable is bit 2 of the status word
// RULE_21 - pin-change reset sets the pin_change_reset_flag
// RULE_22 - sleep takes effect end of write cycle; same-cycle wake cancels entry
`timescale 1ns/10ps
`default_nettype none
module srpf_ctrl #(
   parameter int STAB_CYC = srpf_pkg::STAB_CYC_DEF
) (
   input wire logic CORE_CLK,
   input wire logic RST,
   input wire logic SLEEP_WR,
   input wire logic [7:0] SLEEP_WDATA,
   input wire logic [7:0] PSW,
   input wire logic IRQ_PENDING,
   input wire logic PIN_CHANGE,
   input wire logic SUPPLY_OK,
   input wire logic RESET_PIN_N,
   input wire logic WDT_TIMEOUT,
   input wire logic PFD_DETECT_RAW,
   input wire logic RESET_PIN_ENABLE_FUSE,
   input wire logic PROG_MODE,
   input wire logic CFG_WR,
   input wire logic [15:0] CFG_ADDR,
   input wire logic [7:0] CFG_WDATA,
   input wire logic PFR_WR,
   input wire logic [2:0] PFR_WDATA,
   input wire logic [1:0] PFR_MODE_WDATA,
   input wire logic FLAG_CLR,
   output logic [7:0] SLEEP_CONTROL_REGISTER,
   output logic ASLEEP,
   output logic CPU_RUN,
   output logic TIMERS_RUN,
   output logic PORT_HOLD,
   output logic SYS_RESET,
   output logic CTRL_REG_INIT,
   output logic WAKE_VECTOR,
   output logic WAKE_RESUME,
   output logic SHARED_INPUT_PORT_PIN,
   output logic POWER_FAIL_ENABLE,
   output logic POWER_FAIL_LEVEL_SELECT,
   output logic POWER_FAIL_FILTER,
   output logic CLOCK_FREEZE,
   output logic [4:0] RESET_CAUSE,
   output logic PIN_CHANGE_RESET_FLAG,
   output logic CFG_ACCESS_OK,
   output logic CFG_FUSE_WRITE
);
   typedef struct packed {
      srpf_pkg::srpf_state_t state;
      logic [7:0] sleep_control_register;
      logic [2:0] pfr;
      logic pfr_freeze;
      logic [24:0] stab;
      logic [3:0] pin_cnt;
      logic [srpf_pkg::FILT_LEN-1:0] filt;
      logic [4:0] cause;
      logic vector;
      logic resume;
      logic [4:0] src;
   } srpf_regs_t;

   srpf_regs_t r;
   srpf_regs_t next_r;
   // state decode
   logic in_run;
   logic in_sleep;
   logic in_hold;
   logic in_stab;

   // reset pin qualification
   logic pin_act;
   logic pin_full;
   logic pin_last;
   logic [3:0] pin_inc;

   // power-fail detection path
   logic [srpf_pkg::FILT_LEN-1:0] filt_shift;
   logic pfd_filt_all;
   logic pfd_seen;
   logic pfd_on;
   logic freeze_now;

   // reset sources
   logic src_por;
   logic src_pin;
   logic src_wdt;
   logic src_pfd;
   logic src_pch;
   logic [4:0] src_now;
   logic any_reset;

   // sleep entry and wake
   logic wake_irq;
   logic ie_flag;
   logic sleep_wr_run;
   logic sleep_code_hit;
   logic sleep_enter;

   // start-up delay and register write
   logic [24:0] stab_last;
   logic stab_done;
   logic [24:0] stab_inc;
   logic pfr_take;

   assign in_run = r.state == srpf_pkg::SRPF_RUN;
   assign in_sleep = r.state == srpf_pkg::SRPF_SLEEP;
   assign in_hold = r.state == srpf_pkg::SRPF_HOLD;
   assign in_stab = r.state == srpf_pkg::SRPF_STAB;

   // pin acts as reset only with fuse set
   assign pin_act = RESET_PIN_ENABLE_FUSE && !RESET_PIN_N; // RULE_16
   assign pin_full = r.pin_cnt == srpf_pkg::PIN_MIN_CYC;
   // eighth low cycle is the one that fires
   assign pin_last = r.pin_cnt == srpf_pkg::PIN_MIN_CYC - 4'h1; // RULE_11
   assign pin_inc = r.pin_cnt + 4'h1;

   // detector history, newest sample in bit 0
   assign filt_shift[0] = PFD_DETECT_RAW;
   for (genvar i = 1; i < srpf_pkg::FILT_LEN; i++) begin : g_filt
      assign filt_shift[i] = r.filt[i-1];
   end
   assign pfd_filt_all = &r.filt;
   // filter requires a run of detections when enabled
   assign pfd_seen = r.pfr[srpf_pkg::PFR_FILTER_BIT] ? pfd_filt_all : PFD_DETECT_RAW; // RULE_17
   assign pfd_on = r.pfr[srpf_pkg::PFR_ENABLE_BIT]; // RULE_18
   assign freeze_now = r.pfr_freeze && pfd_on && pfd_seen; // RULE_17

   assign src_por = !SUPPLY_OK; // RULE_15
   assign src_pin = pin_act && pin_last; // RULE_11
   assign src_wdt = WDT_TIMEOUT;
   assign src_pfd = pfd_on && !r.pfr_freeze && pfd_seen; // RULE_18
   // pin change resets only out of sleep
   assign src_pch = in_sleep && PIN_CHANGE; // RULE_07
   assign src_now = {src_pch, src_pfd, src_wdt, src_pin, src_por}; // RULE_14
   assign any_reset = |src_now; // RULE_14

   assign wake_irq = IRQ_PENDING || PIN_CHANGE; // RULE_05
   assign ie_flag = PSW[srpf_pkg::PSW_IE_BIT]; // RULE_20
   assign sleep_wr_run = SLEEP_WR && in_run;
   assign sleep_code_hit = SLEEP_WDATA == srpf_pkg::SLEEP_CODE; // RULE_01
   // a wake in the write cycle cancels entry
   assign sleep_enter = sleep_wr_run && sleep_code_hit && !wake_irq; // RULE_22

   assign stab_last = 25'(STAB_CYC) + srpf_pkg::EXTRA_CYC - 25'h1; // RULE_12
   assign stab_done = r.stab == stab_last;
   assign stab_inc = r.stab + 25'h1;
   assign pfr_take = PFR_WR && in_run; // RULE_17

   always_comb begin
      next_r = r;
      next_r.vector = 1'b0;
      next_r.resume = 1'b0;
      next_r.filt = filt_shift;
      next_r.src = src_now;
      if (!pin_act) begin
         next_r.pin_cnt = srpf_pkg::PIN_CNT_RESET;
      end else if (!pin_full) begin
         // saturates so a long pulse gives one reset
         next_r.pin_cnt = pin_inc; // RULE_11
      end
      if (any_reset) begin
         // control registers reinitialised; ram is outside and untouched
         next_r.state = srpf_pkg::SRPF_HOLD; // RULE_06 RULE_13
         next_r.sleep_control_register = srpf_pkg::SLEEP_CLEAR;
         next_r.pfr = srpf_pkg::PFR_RESET;
         next_r.pfr_freeze = 1'b0;
         next_r.stab = srpf_pkg::CNT_RESET;
         // cause flags are sticky until cleared; set beats clear
         if (FLAG_CLR) begin
            next_r.cause = src_now; // RULE_21
         end else begin
            next_r.cause = r.cause | src_now; // RULE_21
         end
      end else begin
         if (FLAG_CLR) begin
            next_r.cause = srpf_pkg::CAUSE_RESET;
         end
         if (pfr_take) begin
            next_r.pfr = PFR_WDATA; // RULE_17
            next_r.pfr_freeze = PFR_MODE_WDATA[0];
         end
         case (r.state)
            srpf_pkg::SRPF_RUN: begin
               if (sleep_wr_run) begin
                  if (sleep_code_hit) begin
                     // request never persists past acceptance
                     next_r.sleep_control_register = srpf_pkg::SLEEP_CLEAR; // RULE_02
                  end else begin
                     next_r.sleep_control_register = SLEEP_WDATA;
                  end
               end
               if (sleep_enter) begin
                  next_r.state = srpf_pkg::SRPF_SLEEP; // RULE_01 RULE_22
               end
            end
            srpf_pkg::SRPF_SLEEP: begin
               if (IRQ_PENDING) begin
                  // oscillator kept running, so no stabilisation wait
                  next_r.state = srpf_pkg::SRPF_RUN; // RULE_09
                  next_r.vector = ie_flag; // RULE_08
                  next_r.resume = !ie_flag; // RULE_08
               end
            end
            srpf_pkg::SRPF_HOLD: begin
               next_r.state = srpf_pkg::SRPF_STAB;
               next_r.stab = srpf_pkg::CNT_RESET;
            end
            srpf_pkg::SRPF_STAB: begin
               if (stab_done) begin
                  next_r.state = srpf_pkg::SRPF_RUN; // RULE_12
               end else begin
                  next_r.stab = stab_inc;
               end
            end
            default: begin
               next_r.state = srpf_pkg::SRPF_HOLD;
            end
         endcase
      end
      // frozen clock stops the start-up count too
      if (freeze_now) begin
         next_r.stab = r.stab;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         r.state <= srpf_pkg::SRPF_HOLD;
         r.sleep_control_register <= srpf_pkg::SLEEP_CLEAR;
         r.pfr <= srpf_pkg::PFR_RESET;
         r.pfr_freeze <= 1'b0;
         r.stab <= srpf_pkg::CNT_RESET;
         r.pin_cnt <= srpf_pkg::PIN_CNT_RESET;
         r.filt <= srpf_pkg::FILT_RESET;
         r.cause <= srpf_pkg::CAUSE_RESET;
         r.vector <= 1'b0;
         r.resume <= 1'b0;
         r.src <= srpf_pkg::CAUSE_RESET;
      end else begin
         r <= next_r;
      end
   end

   assign SLEEP_CONTROL_REGISTER = r.sleep_control_register;
   assign ASLEEP = in_sleep;
   // cpu halted in sleep, reset hold and stabilisation
   assign CPU_RUN = r.state == srpf_pkg::SRPF_RUN && !CLOCK_FREEZE; // RULE_03
   assign TIMERS_RUN = r.state == srpf_pkg::SRPF_RUN || r.state == srpf_pkg::SRPF_SLEEP;
   assign PORT_HOLD = ASLEEP; // RULE_04
   assign SYS_RESET = in_hold || in_stab;
   assign CTRL_REG_INIT = in_hold; // RULE_06
   assign WAKE_VECTOR = r.vector;
   assign WAKE_RESUME = r.resume;
   assign SHARED_INPUT_PORT_PIN = !RESET_PIN_ENABLE_FUSE && RESET_PIN_N; // RULE_16
   assign POWER_FAIL_ENABLE = r.pfr[srpf_pkg::PFR_ENABLE_BIT]; // RULE_18
   assign POWER_FAIL_LEVEL_SELECT = r.pfr[srpf_pkg::PFR_LEVEL_BIT]; // RULE_18
   assign POWER_FAIL_FILTER = r.pfr[srpf_pkg::PFR_FILTER_BIT];
   assign CLOCK_FREEZE = freeze_now; // RULE_17
   assign RESET_CAUSE = r.cause;
   assign PIN_CHANGE_RESET_FLAG = r.cause[srpf_pkg::CAUSE_PCH]; // RULE_21
   assign CFG_ACCESS_OK = PROG_MODE; // RULE_19
   assign CFG_FUSE_WRITE = PROG_MODE && CFG_WR && CFG_ADDR == srpf_pkg::CFG_FUSE_ADDR
                           && CFG_WDATA != 8'h00; // RULE_19
endmodule
`default_nettype wire

// File: rtl/srpf_pkg.sv
/*
 package of constants for the sleep, reset and power-fail controller.
 assumes a 200 MHz core clock; no other file is needed.
*/
package srpf_pkg;
   localparam int CLK_MHZ = 200;
   localparam int CLK_PERIOD_PS = 5000;
   localparam logic [7:0] SLEEP_CODE = 8'h0f;
   localparam logic [7:0] SLEEP_CLEAR = 8'h00;
   localparam logic [15:0] CFG_FUSE_ADDR = 16'h201f;
   localparam int PSW_IE_BIT = 2;
   // external reset pulse, oscillator periods
   localparam int PIN_MIN_OSC = 8;
   localparam logic [3:0] PIN_MIN_CYC = 4'(PIN_MIN_OSC);
   // start-up stabilisation, in microseconds, plus trailing periods
   localparam int STAB_US = 65500;
   localparam int STAB_CYC_DEF = STAB_US * CLK_MHZ;
   localparam int EXTRA_OSC = 7;
   localparam logic [24:0] EXTRA_CYC = 25'(EXTRA_OSC);
   localparam logic [24:0] CNT_RESET = 25'h0000000;
   localparam logic [3:0] PIN_CNT_RESET = 4'h0;
   localparam logic [2:0] PFR_RESET = 3'h0;
   localparam int PFR_ENABLE_BIT = 0;
   localparam int PFR_LEVEL_BIT = 1;
   localparam int PFR_FILTER_BIT = 2;
   localparam logic [1:0] PFR_MODE_RESET = 2'h0;
   localparam logic [4:0] CAUSE_RESET = 5'h00;
   localparam int CAUSE_POR = 0;
   localparam int CAUSE_PIN = 1;
   localparam int CAUSE_WDT = 2;
   localparam int CAUSE_PFD = 3;
   localparam int CAUSE_PCH = 4;
   localparam int FILT_LEN = 4;
   localparam logic [FILT_LEN-1:0] FILT_RESET = 4'h0;
   typedef enum logic [1:0] {SRPF_RUN, SRPF_SLEEP, SRPF_HOLD, SRPF_STAB} srpf_state_t;
endpackage

// File: verification/srpf_chk_assertions.sv
/* checker for the sleep, reset and power-fail controller.
 bound from tb; sees only the top ports. */
`timescale 1ns/10ps
`default_nettype none
module srpf_chk (
   input wire logic CORE_CLK,
   input wire logic RST,
   input wire logic SLEEP_WR,
   input wire logic [7:0] SLEEP_WDATA,
   input wire logic [7:0] PSW,
   input wire logic IRQ_PENDING,
   input wire logic PIN_CHANGE,
   input wire logic SUPPLY_OK,
   input wire logic RESET_PIN_N,
   input wire logic RESET_PIN_ENABLE_FUSE,
   input wire logic [7:0] SLEEP_CONTROL_REGISTER,
   input wire logic ASLEEP,
   input wire logic CPU_RUN,
   input wire logic TIMERS_RUN,
   input wire logic PORT_HOLD,
   input wire logic SYS_RESET,
   input wire logic WAKE_VECTOR,
   input wire logic WAKE_RESUME,
   input wire logic SHARED_INPUT_PORT_PIN,
   input wire logic PIN_CHANGE_RESET_FLAG
);
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (RST);
   sleep_entry_a: assert property (
      SLEEP_WR && SLEEP_WDATA == 8'h0f && CPU_RUN && !IRQ_PENDING && !PIN_CHANGE
      |=> ASLEEP && SLEEP_CONTROL_REGISTER == 8'h00) else $error("sleep entry");
   sleep_hold_a: assert property (ASLEEP
      |-> !CPU_RUN && TIMERS_RUN && PORT_HOLD) else $error("sleep hold");
   wake_vector_a: assert property (
      ASLEEP && IRQ_PENDING && !PIN_CHANGE && PSW[2] && SUPPLY_OK
      |=> !ASLEEP && CPU_RUN && WAKE_VECTOR && !WAKE_RESUME) else $error("wake vector");
   wake_resume_a: assert property (
      ASLEEP && IRQ_PENDING && !PIN_CHANGE && !PSW[2] && SUPPLY_OK
      |=> !ASLEEP && CPU_RUN && WAKE_RESUME && !WAKE_VECTOR) else $error("wake resume");
   pin_wake_a: assert property (ASLEEP && PIN_CHANGE
      |-> ##[1:3] SYS_RESET && PIN_CHANGE_RESET_FLAG) else $error("pin change wake");
   wake_cancel_a: assert property (SLEEP_WR && CPU_RUN
      && (IRQ_PENDING || PIN_CHANGE) |=> !ASLEEP) else $error("entry not cancelled");
   fuse_pin_a: assert property (!RESET_PIN_ENABLE_FUSE
      |-> SHARED_INPUT_PORT_PIN == RESET_PIN_N) else $error("shared pin");
   supply_hold_a: assert property (!SUPPLY_OK
      |=> ##[0:1] SYS_RESET && !CPU_RUN) else $error("supply hold");
endmodule
`default_nettype wire

// File: verification/srpf_ext_rst.sv
/* external reset source on the reset pin.
 started by tb; the pin has a pull-up, so it reads high once released. */
`timescale 1ns/10ps
`default_nettype none
module srpf_ext_rst (
   input wire logic clk,
   input wire logic go,
   input wire logic [3:0] low_cyc,
   output logic pin_n
);
   logic [3:0] cnt = 4'h0;
   always @(posedge clk) begin
      if (go) cnt <= low_cyc;
      else if (cnt != 4'h0) cnt <= cnt - 4'h1;
   end
   assign pin_n = (cnt == 4'h0);
endmodule
`default_nettype wire

// File: verification/tb.sv
/* self-checking bench for the sleep, reset and power-fail controller.
 needs the package, the design, the reset source model and the checker. */
`timescale 1ns/10ps
`default_nettype none
module tb;
   localparam int STAB = 20;
   logic CORE_CLK = 1'b0, RST = 1'b1, SLEEP_WR = 1'b0, IRQ_PENDING = 1'b0, PIN_CHANGE = 1'b0;
   logic SUPPLY_OK = 1'b1, WDT_TIMEOUT = 1'b0, PFD_DETECT_RAW = 1'b0, PROG_MODE = 1'b0;
   logic RESET_PIN_ENABLE_FUSE = 1'b1, CFG_WR = 1'b0, PFR_WR = 1'b0, FLAG_CLR = 1'b0, go = 1'b0;
   logic [7:0] SLEEP_WDATA = 8'h00, PSW = 8'h00, CFG_WDATA = 8'h00, SLEEP_CONTROL_REGISTER;
   logic [15:0] CFG_ADDR = 16'h0000;
   logic [2:0] PFR_WDATA = 3'h0;
   logic [1:0] PFR_MODE_WDATA = 2'h0;
   logic [3:0] low = 4'h7;
   logic [4:0] RESET_CAUSE;
   logic RESET_PIN_N, ASLEEP, CPU_RUN, TIMERS_RUN, PORT_HOLD, SYS_RESET, CTRL_REG_INIT;
   logic WAKE_VECTOR, WAKE_RESUME, SHARED_INPUT_PORT_PIN, POWER_FAIL_ENABLE, CLOCK_FREEZE;
   logic POWER_FAIL_LEVEL_SELECT, POWER_FAIL_FILTER, PIN_CHANGE_RESET_FLAG, CFG_ACCESS_OK;
   logic CFG_FUSE_WRITE;
   int failures = 0, n_checks = 0, n;
   srpf_ctrl #(.STAB_CYC(STAB)) DUT (.*);
   srpf_ext_rst u_pin (.clk(CORE_CLK), .go(go), .low_cyc(low), .pin_n(RESET_PIN_N));
   always #2.5 CORE_CLK = ~CORE_CLK;
   task automatic stop_test;
      if (failures == 0 && n_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input logic ok, input string m);
      n_checks++;
      if (ok !== 1'b1) begin
         failures++;
         $display("BAD %0t %s", $time, m);
      end
   endtask
   task automatic cyc(input int k);
      repeat (k) @(negedge CORE_CLK);
   endtask
   task automatic wait_run;
      n = 0;
      while (CPU_RUN !== 1'b1 && n < 60) begin
         cyc(1);
         n++;
      end
   endtask
   task automatic t_sleep(input logic ie, input logic [7:0] d, input logic wake);
      PSW = {5'h00, ie, 2'h0};
      SLEEP_WR = 1'b1;
      SLEEP_WDATA = d;
      IRQ_PENDING = wake;
      cyc(1);
      // write strobe and wake drop after one cycle; callers may drive the next write or pin change at once
      SLEEP_WR = 1'b0;
      IRQ_PENDING = 1'b0;
   endtask
   task automatic t_wake(input logic ie);
      t_sleep(ie, 8'h0f, 1'b0);
      chk(ASLEEP === 1'b1 && CPU_RUN === 1'b0 && SLEEP_CONTROL_REGISTER === 8'h00, "enter");
      chk(TIMERS_RUN === 1'b1 && PORT_HOLD === 1'b1, "sleep keeps");
      cyc(3);
      IRQ_PENDING = 1'b1;
      cyc(1);
      IRQ_PENDING = 1'b0;
      chk(ASLEEP === 1'b0 && CPU_RUN === 1'b1 && WAKE_VECTOR === ie && WAKE_RESUME === !ie, "wake");
      cyc(1);
      chk(WAKE_VECTOR === 1'b0 && WAKE_RESUME === 1'b0, "wake pulse");
   endtask
   task automatic t_src(input int i, input int b);
      WDT_TIMEOUT = (i == 0);
      SUPPLY_OK = (i != 1);
      PFD_DETECT_RAW = (i == 2);
      cyc(6);
      WDT_TIMEOUT = 1'b0;
      SUPPLY_OK = 1'b1;
      PFD_DETECT_RAW = 1'b0;
      chk(SYS_RESET === 1'b1 && RESET_CAUSE[b] === 1'b1, "reset source");
      wait_run;
   endtask
   task automatic t_start;
      cyc(4);
      chk(CTRL_REG_INIT === 1'b1 && SYS_RESET === 1'b1 && CPU_RUN === 1'b0, "hold");
      RST = 1'b0;
      wait_run;
      chk(n >= STAB + 7 && n <= STAB + 11 && RESET_CAUSE === 5'h00, "start delay");
   endtask
   task automatic t_cancel;
      t_sleep(1'b0, 8'h0f, 1'b1);
      chk(ASLEEP === 1'b0, "cancel");
      PIN_CHANGE = 1'b1;
      t_sleep(1'b0, 8'h0f, 1'b0);
      PIN_CHANGE = 1'b0;
      chk(ASLEEP === 1'b0 && SYS_RESET === 1'b0, "cancel pin");
      t_sleep(1'b0, 8'h5a, 1'b0);
      chk(ASLEEP === 1'b0 && SLEEP_CONTROL_REGISTER === 8'h5a, "store");
   endtask
   task automatic t_pfr(input logic [2:0] d, input logic [1:0] m);
      PFR_WR = 1'b1;
      PFR_WDATA = d;
      PFR_MODE_WDATA = m;
      cyc(1);
      PFR_WR = 1'b0;
   endtask
   task automatic t_pin;
      t_pfr(3'h3, 2'h0);
      chk(POWER_FAIL_ENABLE === 1'b1 && POWER_FAIL_LEVEL_SELECT === 1'b1, "pfr");
      RESET_PIN_ENABLE_FUSE = 1'b0;
      low = 4'h8;
      go = 1'b1;
      cyc(1);
      go = 1'b0;
      chk(SHARED_INPUT_PORT_PIN === 1'b0, "plain pin");
      cyc(10);
      chk(SYS_RESET === 1'b0 && POWER_FAIL_ENABLE === 1'b1, "pin ignored");
      chk(SHARED_INPUT_PORT_PIN === 1'b1, "plain pin high");
      RESET_PIN_ENABLE_FUSE = 1'b1;
      low = 4'h7;
      go = 1'b1;
      cyc(1);
      go = 1'b0;
      cyc(10);
      chk(SYS_RESET === 1'b0, "short pulse");
      low = 4'h8;
      go = 1'b1;
      cyc(1);
      go = 1'b0;
      cyc(10);
      chk(SYS_RESET === 1'b1 && RESET_CAUSE[1] === 1'b1, "pin reset");
      wait_run;
   endtask
   task automatic t_pch;
      t_sleep(1'b0, 8'h0f, 1'b0);
      PIN_CHANGE = 1'b1;
      cyc(1);
      PIN_CHANGE = 1'b0;
      chk(CTRL_REG_INIT === 1'b1 && SYS_RESET === 1'b1, "pch init");
      cyc(2);
      chk(SYS_RESET === 1'b1 && PIN_CHANGE_RESET_FLAG === 1'b1, "pin change");
      wait_run;
      FLAG_CLR = 1'b1;
      cyc(1);
      FLAG_CLR = 1'b0;
      chk(RESET_CAUSE === 5'h00, "flag clear");
   endtask
   task automatic t_freeze;
      t_pfr(3'h5, 2'h1);
      PFD_DETECT_RAW = 1'b1;
      cyc(3);
      chk(CLOCK_FREEZE === 1'b0 && CPU_RUN === 1'b1, "filter short");
      cyc(1);
      chk(CLOCK_FREEZE === 1'b1 && CPU_RUN === 1'b0 && SYS_RESET === 1'b0, "freeze");
      chk(POWER_FAIL_FILTER === 1'b1, "filter bit");
      PFD_DETECT_RAW = 1'b0;
      cyc(1);
      chk(CLOCK_FREEZE === 1'b0 && CPU_RUN === 1'b1, "unfreeze");
      PFR_MODE_WDATA = 2'h0;
   endtask
   task automatic t_cfg;
      CFG_WR = 1'b1;
      CFG_ADDR = srpf_pkg::CFG_FUSE_ADDR;
      CFG_WDATA = 8'h01;
      #1;
      chk(CFG_FUSE_WRITE === 1'b0 && CFG_ACCESS_OK === 1'b0, "cfg locked");
      PROG_MODE = 1'b1;
      #1;
      chk(CFG_FUSE_WRITE === 1'b1 && CFG_ACCESS_OK === 1'b1, "cfg open");
      CFG_WR = 1'b0;
      PROG_MODE = 1'b0;
      cyc(1);
   endtask
   initial begin
      t_start;
      t_wake(1'b1);
      t_wake(1'b0);
      t_cancel;
      t_pin;
      t_pch;
      t_freeze;
      t_cfg;
      t_pfr(3'h1, 2'h0);
      t_src(2, srpf_pkg::CAUSE_PFD);
      t_src(0, srpf_pkg::CAUSE_WDT);
      t_src(1, srpf_pkg::CAUSE_POR);
      stop_test;
   end
   initial begin
      repeat (2000) @(posedge CORE_CLK);
      failures++;
      stop_test;
   end
endmodule
bind srpf_ctrl srpf_chk u_chk (.*);
`default_nettype wire
